//--- otp_ecc_ctrl.sv
// otp page programming control and ecc encoder/decoder self-test, apb slave
//
// Overview of operation
// - page_select zero picks first customer page, one picks second
// - writing program_start one programs selected page; zero reads idle
// - programming starts only when both unlock codes are correct
// - decoder_test_select zero tests single-error, one double-error; flag
// - encoder test ignores decoder_test_select completely
// - fault flags stay set until fault-clear bit written with one
// - switching decoder test kind keeps the other latched flag
// - data source zero uses internal data, one uses test input bytes
// - coder_test_select zero runs decoder test, one runs encoder test
// - test enable one launches configured test, zero is normal mode
// - manual encoder operand is input bytes eight down to one
// - manual decoder operand is input bytes nine down to one
// - decoder fills result bytes eight..one, encoder nine..one
// - unlock codes are 32 bits, written bytewise, read back zero
// - unlock bit set on success, cleared by start or by writes to registers other than program control and the unlock codes
// - done reads one after programming completes, start clears it
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
module otp_ecc_ctrl
  import otp_ecc_pkg::*;
#(
  parameter logic [31:0] FIRST_UNLOCK_CODE  = 32'h1234_5678,
  parameter logic [31:0] SECOND_UNLOCK_CODE = 32'h9ABC_DEF0
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             prog_active,
  output logic             prog_page
);

  // ----------------------------------------------------------------
  // ecc helpers: extended hamming, 64 data bits in a 72-bit codeword
  // ----------------------------------------------------------------
  function automatic logic [71:0] ecc_encode(input logic [63:0] d);
    logic [71:0] cw;
    logic        par;
    int          k;
    cw = '0;
    k  = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        cw[p] = d[k];
        k++;
      end
    end
    for (int b = 0; b < 7; b++) begin
      par = 1'b0;
      for (int p = 1; p < 72; p++) begin
        if (p[b]) par ^= cw[p];
      end
      cw[1 << b] = par;
    end
    cw[0] = ^cw[71:1];
    return cw;
  endfunction : ecc_encode

  // returns {single, double, corrected data}
  function automatic logic [65:0] ecc_decode(input logic [71:0] cw_in);
    logic [71:0] cw;
    logic [6:0]  syn;
    logic        all;
    logic        single;
    logic        dbl;
    logic [63:0] d;
    int          k;
    cw     = cw_in;
    syn    = '0;
    single = 1'b0;
    dbl    = 1'b0;
    d      = '0;
    k      = 0;
    for (int p = 1; p < 72; p++) begin
      if (cw[p]) syn ^= 7'(p);
    end
    all = ^cw;
    if (syn != 7'h00 && all) begin
      single = 1'b1;
      if (syn < 7'd72) cw[syn] = ~cw[syn];
    end else if (syn == 7'h00 && all) begin
      single = 1'b1;
    end else if (syn != 7'h00) begin
      dbl = 1'b1;
    end
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = cw[p];
        k++;
      end
    end
    return {single, dbl, d};
  endfunction : ecc_decode

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  state_t      s_r;
  state_t      s_nxt;
  logic [13:0] idx;
  logic        aligned;
  logic        mapped;
  logic        wr_en;
  logic        rd_setup;
  logic [7:0]  wbyte;
  logic        is_unlock;
  logic [71:0] enc_cw;
  logic [71:0] dec_cw;
  logic [65:0] dec_res;
  logic        start_wr;

  assign idx      = paddr[15:2];
  assign aligned  = (paddr[1:0] == 2'b00);
  assign wbyte    = pwdata[7:0];
  assign mapped   = aligned &&
                    ((idx >= IDX_UNLOCK1_A && idx <= IDX_UNLOCK1_D) ||
                     (idx >= IDX_UNLOCK2_A && idx <= IDX_UNLOCK2_D) ||
                     (idx >= IDX_ECC_IN1   && idx <= IDX_ECC_TEST)  ||
                     (idx >= IDX_ECC_OUT1  && idx <= IDX_PROG_STAT) ||
                     (idx >= IDX_FAULT_STAT && idx <= IDX_IRQ_MASK) ||
                     idx == IDX_PROG_CTRL);
  // a write lands only at the completing edge of the access phase
  assign wr_en    = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign is_unlock = (idx >= IDX_UNLOCK1_A && idx <= IDX_UNLOCK1_D) ||
                     (idx >= IDX_UNLOCK2_A && idx <= IDX_UNLOCK2_D);
  assign start_wr = wr_en && idx == IDX_PROG_CTRL && pwdata[PC_START];

  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !mapped;
  assign prdata      = s_r.prdata;
  assign irq         = |(s_r.irq_stat & s_r.irq_mask);
  assign prog_active = s_r.prog_busy;
  assign prog_page   = s_r.prog_page;

  // ----------------------------------------------------------------
  // test operands
  // ----------------------------------------------------------------
  always_comb begin
    enc_cw = ecc_encode(s_r.manual ? s_r.din[63:0] : AUTO_DATA);
    if (s_r.manual) begin
      dec_cw = s_r.din;
    end else begin
      // internal pattern carries one flipped bit, or two for the ded test
      dec_cw = ecc_encode(AUTO_DATA);
      dec_cw[AUTO_FLIP_A] = ~dec_cw[AUTO_FLIP_A];
      if (s_r.dec_sel) dec_cw[AUTO_FLIP_B] = ~dec_cw[AUTO_FLIP_B];
    end
    dec_res = ecc_decode(dec_cw);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] w1c;
    logic [31:0]      c1;
    logic [31:0]      c2;
    logic [3:0]       bsel;
    logic [1:0]       ofs;
    ev    = '0;
    w1c   = '0;
    c1    = s_r.code1;
    c2    = s_r.code2;
    bsel  = 4'h0;
    ofs   = 2'b00;
    s_nxt = s_r;

    // programming timer
    if (s_r.prog_busy) begin
      s_nxt.prog_cnt = s_r.prog_cnt - 16'h0001;
      if (s_r.prog_cnt == 16'h0001) begin
        s_nxt.prog_busy = 1'b0;
        s_nxt.done      = 1'b1;
        ev[IRQ_DONE]    = 1'b1;
      end
    end

    // one-cycle test run, enable self-clears, results held
    if (s_r.enable) begin
      s_nxt.enable  = 1'b0;
      ev[IRQ_TEST]  = 1'b1;
      if (s_r.coder) begin
        s_nxt.dout = enc_cw;
      end else begin
        s_nxt.dout = {BYTE_RST, dec_res[63:0]};
        if (!s_r.dec_sel && dec_res[65]) ev[IRQ_SEC] = 1'b1;
        if (s_r.dec_sel && dec_res[64])  ev[IRQ_DED] = 1'b1;
      end
    end

    // register writes
    if (wr_en) begin
      if (!is_unlock && idx != IDX_PROG_CTRL) s_nxt.unlock = 1'b0;
      case (idx)
        IDX_PROG_CTRL: begin
          s_nxt.page_select = pwdata[PC_PAGE];
          if (pwdata[PC_START] && !s_r.prog_busy) begin
            if (s_r.unlock) begin
              s_nxt.prog_busy = 1'b1;
              s_nxt.prog_cnt  = PROG_CYCLES;
              s_nxt.prog_page = pwdata[PC_PAGE];
              s_nxt.progerr   = 1'b0;
            end else begin
              s_nxt.progerr    = 1'b1;
              ev[IRQ_PROGERR]  = 1'b1;
            end
            s_nxt.done   = 1'b0;
            s_nxt.unlock = 1'b0;
            s_nxt.code1  = '0;
            s_nxt.code2  = '0;
          end
        end
        IDX_ECC_TEST: begin
          s_nxt.dec_sel = pwdata[ET_DEC_SEL];
          s_nxt.manual  = pwdata[ET_MANUAL];
          s_nxt.coder   = pwdata[ET_CODER];
          s_nxt.enable  = pwdata[ET_ENABLE];
        end
        IDX_FAULT_RESET: begin
          // fault-clear write; a same-cycle set still wins below
          if (pwdata[FR_CLEAR]) begin
            s_nxt.sec = 1'b0;
            s_nxt.ded = 1'b0;
          end
        end
        IDX_IRQ_STAT: w1c = pwdata[IRQ_W-1:0];
        IDX_IRQ_MASK: s_nxt.irq_mask = pwdata[IRQ_W-1:0];
        default: begin
          // unlock bytes, lowest index of each set is most significant
          if (is_unlock) begin
            // set two does not start on a four-aligned index, so the byte
            // slot is counted from the base of its own set
            ofs  = idx[1:0] - (idx <= IDX_UNLOCK1_D ? IDX_UNLOCK1_A[1:0]
                                                   : IDX_UNLOCK2_A[1:0]);
            bsel = 4'h8 >> ofs;
            if (idx <= IDX_UNLOCK1_D) begin
              for (int i = 0; i < 4; i++) begin
                if (bsel[i]) c1[8*i +: 8] = wbyte;
              end
            end else begin
              for (int i = 0; i < 4; i++) begin
                if (bsel[i]) c2[8*i +: 8] = wbyte;
              end
            end
            s_nxt.code1 = c1;
            s_nxt.code2 = c2;
            // both sets checked on each last-byte write
            if ((idx == IDX_UNLOCK1_D || idx == IDX_UNLOCK2_D) &&
                c1 == FIRST_UNLOCK_CODE && c2 == SECOND_UNLOCK_CODE) begin
              s_nxt.unlock = 1'b1;
            end
          end
          for (int n = 0; n < 9; n++) begin
            if (idx == IDX_ECC_IN1 + 14'(n)) s_nxt.din[8*n +: 8] = wbyte;
          end
        end
      endcase
    end

    // each flag only ever set by its own test kind
    if (ev[IRQ_SEC]) s_nxt.sec = 1'b1;
    if (ev[IRQ_DED]) s_nxt.ded = 1'b1;
    s_nxt.irq_stat = (s_r.irq_stat & ~w1c) | ev;

    // read data is caught in the setup phase
    if (rd_setup) begin
      s_nxt.prdata = '0;
      case (idx)
        IDX_PROG_CTRL: begin
          s_nxt.prdata[PC_PAGE]  = s_r.page_select;
          s_nxt.prdata[PC_START] = s_r.prog_busy;
        end
        IDX_ECC_TEST: begin
          s_nxt.prdata[ET_DEC_SEL] = s_r.dec_sel;
          s_nxt.prdata[ET_MANUAL]  = s_r.manual;
          s_nxt.prdata[ET_CODER]   = s_r.coder;
          s_nxt.prdata[ET_ENABLE]  = s_r.enable;
        end
        IDX_PROG_STAT: begin
          s_nxt.prdata[PS_UNLOCK]  = s_r.unlock;
          s_nxt.prdata[PS_PROGERR] = s_r.progerr;
          s_nxt.prdata[PS_DONE]    = s_r.done;
        end
        IDX_FAULT_STAT: begin
          s_nxt.prdata[FS_SEC] = s_r.sec;
          s_nxt.prdata[FS_DED] = s_r.ded;
        end
        IDX_IRQ_STAT: s_nxt.prdata[IRQ_W-1:0] = s_r.irq_stat;
        IDX_IRQ_MASK: s_nxt.prdata[IRQ_W-1:0] = s_r.irq_mask;
        default: begin
          for (int n = 0; n < 9; n++) begin
            if (aligned && idx == IDX_ECC_IN1 + 14'(n))
              s_nxt.prdata[7:0] = s_r.din[8*n +: 8];
            if (aligned && idx == IDX_ECC_OUT1 + 14'(n))
              s_nxt.prdata[7:0] = s_r.dout[8*n +: 8];
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start_locked;
    start_wr && !s_r.unlock && !s_r.prog_busy;
  endsequence

  sequence s_start_ok;
    start_wr && s_r.unlock && !s_r.prog_busy;
  endsequence

  property p_refuse_locked;
    s_start_locked |=> !s_r.prog_busy && s_r.progerr;
  endproperty
  a_refuse_locked: assert property (p_refuse_locked)
    else $error("programming started while locked");

  property p_start_runs;
    s_start_ok |=> s_r.prog_busy && !s_r.done && !s_r.unlock;
  endproperty
  a_start_runs: assert property (p_start_runs)
    else $error("accepted start did not begin programming");

  property p_page_taken;
    s_start_ok |=> s_r.prog_page == $past(pwdata[PC_PAGE]);
  endproperty
  a_page_taken: assert property (p_page_taken)
    else $error("programmed page differs from page select");

  property p_relock;
    wr_en && !is_unlock && idx != IDX_PROG_CTRL |=> !s_r.unlock;
  endproperty
  a_relock: assert property (p_relock)
    else $error("unlock survived a write to another register");

  property p_done_after;
    s_r.prog_busy && s_r.prog_cnt == 16'h0001 && !start_wr
      |=> s_r.done && !s_r.prog_busy && s_r.irq_stat[IRQ_DONE];
  endproperty
  a_done_after: assert property (p_done_after)
    else $error("done not raised at end of programming");

  property p_enable_clears;
    s_r.enable &&
      !(wr_en && idx == IDX_ECC_TEST && pwdata[ET_ENABLE]) |=> !s_r.enable;
  endproperty
  a_enable_clears: assert property (p_enable_clears)
    else $error("test enable did not self-clear");

  property p_enc_result;
    s_r.enable && s_r.coder |=> s_r.dout == $past(enc_cw);
  endproperty
  a_enc_result: assert property (p_enc_result)
    else $error("encoder result bytes wrong");

  property p_flag_hold;
    s_r.sec && !(wr_en && idx == IDX_FAULT_RESET && pwdata[FR_CLEAR])
      |=> s_r.sec;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("single-error flag dropped without clear");

  property p_other_kept;
    s_r.ded && s_r.enable && !s_r.dec_sel &&
      !(wr_en && idx == IDX_FAULT_RESET) |=> s_r.ded;
  endproperty
  a_other_kept: assert property (p_other_kept)
    else $error("single-error test disturbed double-error flag");

  property p_unlock_reads_zero;
    rd_setup && aligned && is_unlock |=> s_r.prdata == 32'h0000_0000;
  endproperty
  a_unlock_reads_zero: assert property (p_unlock_reads_zero)
    else $error("unlock register read non-zero");

endmodule : otp_ecc_ctrl

//--- otp_ecc_pkg.sv
// constants and state type for the otp programming and ecc self-test block
package otp_ecc_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [13:0] IDX_UNLOCK1_A   = 14'h0300;
  localparam logic [13:0] IDX_UNLOCK1_D   = 14'h0303;
  localparam logic [13:0] IDX_PROG_CTRL   = 14'h030B;
  localparam logic [13:0] IDX_ECC_IN1     = 14'h0343;
  localparam logic [13:0] IDX_ECC_IN9     = 14'h034B;
  localparam logic [13:0] IDX_ECC_TEST    = 14'h034C;
  localparam logic [13:0] IDX_UNLOCK2_A   = 14'h0352;
  localparam logic [13:0] IDX_UNLOCK2_D   = 14'h0355;
  localparam logic [13:0] IDX_ECC_OUT1    = 14'h0510;
  localparam logic [13:0] IDX_ECC_OUT9    = 14'h0518;
  localparam logic [13:0] IDX_PROG_STAT   = 14'h0519;
  localparam logic [13:0] IDX_FAULT_STAT  = 14'h0600;
  localparam logic [13:0] IDX_FAULT_RESET = 14'h0601;
  localparam logic [13:0] IDX_IRQ_STAT    = 14'h0602;
  localparam logic [13:0] IDX_IRQ_MASK    = 14'h0603;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PC_PAGE     = 5;
  localparam int PC_START    = 4;
  localparam int ET_DEC_SEL  = 3;
  localparam int ET_MANUAL   = 2;
  localparam int ET_CODER    = 1;
  localparam int ET_ENABLE   = 0;
  localparam int PS_UNLOCK   = 7;
  localparam int PS_PROGERR  = 1;
  localparam int PS_DONE     = 0;
  localparam int FS_SEC      = 0;
  localparam int FS_DED      = 1;
  localparam int FR_CLEAR    = 0;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_PROGERR = 1;
  localparam int IRQ_TEST    = 2;
  localparam int IRQ_SEC     = 3;
  localparam int IRQ_DED     = 4;
  localparam int IRQ_W       = 5;

  // ----------------------------------------------------------------
  // reset values, timing and internal test pattern
  // ----------------------------------------------------------------
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic [15:0] PROG_CYCLES  = 16'h03E8;
  localparam logic [63:0] AUTO_DATA    = 64'hA5C3_0F96_5A3C_F069;
  localparam int          AUTO_FLIP_A  = 13;
  localparam int          AUTO_FLIP_B  = 42;

  typedef struct packed {
    logic        page_select;
    logic        prog_busy;
    logic [15:0] prog_cnt;
    logic        prog_page;
    logic [31:0] code1;
    logic [31:0] code2;
    logic        unlock;
    logic        done;
    logic        progerr;
    logic        dec_sel;
    logic        manual;
    logic        coder;
    logic        enable;
    logic [71:0] din;
    logic [71:0] dout;
    logic        sec;
    logic        ded;
    logic [4:0]  irq_stat;
    logic [4:0]  irq_mask;
    logic [31:0] prdata;
  } state_t;

endpackage : otp_ecc_pkg

//--- otp_program_ecc_selftest_tb.sv
// self-checking testbench for the otp programming and ecc self-test block
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (g), (e)); \
  end end
module otp_program_ecc_selftest_tb;
  import otp_ecc_pkg::*;

  // unlock codes are arbitrary, only bench and design must agree
  localparam logic [31:0] CODE1 = 32'h1234_5678;
  localparam logic [31:0] CODE2 = 32'h9ABC_DEF0;
  localparam logic [63:0] DATA  = 64'h0123_4567_89AB_CDEF;

  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [15:0] paddr   = 16'h0000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        prog_active;
  logic        prog_page;
  logic [31:0] rdat;
  logic        last_err;
  logic [71:0] r;
  logic [71:0] cw;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          k;
  int          w;

  otp_ecc_ctrl #(
    .FIRST_UNLOCK_CODE  (CODE1),
    .SECOND_UNLOCK_CODE (CODE2)
  ) i_otp_ecc_ctrl (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .irq         (irq),
    .prog_active (prog_active),
    .prog_page   (prog_page)
  );

  always #5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // reference encoder, written independently of the design
  // ----------------------------------------------------------------
  function automatic logic [71:0] enc(input logic [63:0] d);
    logic [71:0] c;
    int          j;
    c = '0;
    j = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = d[j];
        j++;
      end
    end
    for (int q = 1; q < 72; q = q * 2) begin
      for (int p = 1; p < 72; p++) begin
        if (((p & q) != 0) && (p != q)) c[q] = c[q] ^ c[p];
      end
    end
    c[0] = ^c[71:1];
    return c;
  endfunction : enc

  // ----------------------------------------------------------------
  // apb master tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= 1'b1;
    paddr  <= {idx, 2'h0};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : wr

  task automatic rd(input logic [13:0] idx);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= 1'b0;
    paddr  <= {idx, 2'h0};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat     = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : rd

  task automatic rchk(input logic [13:0] idx, input logic [7:0] e);
    rd(idx);
    `CHK(rdat, {24'h00_0000, e})
  endtask : rchk

  task automatic wr_in(input logic [71:0] v);
    for (int i = 0; i < 9; i++) wr(IDX_ECC_IN1 + 14'(i), v[8*i +: 8]);
  endtask : wr_in

  task automatic rd_res();
    for (int i = 0; i < 9; i++) begin
      rd(IDX_ECC_OUT1 + 14'(i));
      r[8*i +: 8] = rdat[7:0];
    end
  endtask : rd_res

  // code bytes go most significant first, set one before set two
  // bytewise code entry
  task automatic unlock(input logic [31:0] a, input logic [31:0] b);
    for (int i = 0; i < 4; i++) wr(IDX_UNLOCK1_A + 14'(i), a[31-8*i -: 8]);
    for (int i = 0; i < 4; i++) wr(IDX_UNLOCK2_A + 14'(i), b[31-8*i -: 8]);
  endtask : unlock

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // watchdog: two programming runs plus a few hundred transfers
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (k = 0; k < 9; k++) begin
      rchk(IDX_ECC_IN1 + 14'(k), 8'h00);
      rchk(IDX_ECC_OUT1 + 14'(k), 8'h00);
    end
    rchk(IDX_ECC_TEST, 8'h00);
    rchk(IDX_PROG_STAT, 8'h00);
    rchk(IDX_PROG_CTRL, 8'h00);
    `CHK(irq, 1'b0)
    rd(14'h0001);
    `CHK({last_err, rdat}, {1'b1, 32'h0000_0000})
    // read-only result bytes ignore writes
    wr(IDX_ECC_OUT1, 8'hFF);
    rchk(IDX_ECC_OUT1, 8'h00);
    // start while locked is refused
    wr(IDX_PROG_CTRL, 8'h10);
    @(posedge pclk);
    `CHK(prog_active, 1'b0)
    rchk(IDX_PROG_STAT, 8'h02);
    unlock(CODE1, ~CODE2);
    rchk(IDX_PROG_STAT, 8'h02);
    unlock(CODE1, CODE2);
    rchk(IDX_UNLOCK1_A, 8'h00);
    rchk(IDX_UNLOCK2_D, 8'h00);
    rchk(IDX_PROG_STAT, 8'h82);
    wr(IDX_ECC_IN1, 8'h00);
    rchk(IDX_PROG_STAT, 8'h02);
    // program page one then page two
    for (k = 0; k < 2; k++) begin
      unlock(CODE1, CODE2);
      wr(IDX_PROG_CTRL, {2'h0, k[0], 1'b1, 4'h0});
      @(posedge pclk);
      `CHK({prog_active, prog_page}, {1'b1, k[0]})
      rchk(IDX_PROG_STAT, 8'h00);
      rchk(IDX_PROG_CTRL, {2'h0, k[0], 1'b1, 4'h0});
      w = 0;
      while (prog_active === 1'b1 && w < 1100) begin
        @(posedge pclk);
        w++;
      end
      `CHK(w > 900 && w < 1000, 1'b1)
      rchk(IDX_PROG_STAT, 8'h01);
      rchk(IDX_PROG_CTRL, {2'h0, k[0], 5'h00});
    end
    // interrupt: masked, unmasked, cleared
    `CHK(irq, 1'b0)
    rchk(IDX_IRQ_STAT, 8'h03);
    wr(IDX_IRQ_MASK, 8'h01);
    @(posedge pclk);
    `CHK(irq, 1'b1)
    wr(IDX_IRQ_STAT, 8'h03);
    @(posedge pclk);
    `CHK(irq, 1'b0)
    // auto encoder, decoder selector must not matter
    for (k = 0; k < 2; k++) begin
      wr(IDX_ECC_TEST, {4'h0, k[0], 3'h3});
      rd_res();
      `CHK(r, enc(AUTO_DATA))
      rchk(IDX_ECC_TEST, {4'h0, k[0], 3'h2});
      rchk(IDX_FAULT_STAT, 8'h00);
    end
    // manual encoder: byte nine is not part of the operand
    cw = {8'hEE, DATA};
    wr_in(cw);
    wr(IDX_ECC_TEST, 8'h07);
    rd_res();
    `CHK(r, enc(DATA))
    // manual decoder with one flipped bit
    cw = enc(DATA);
    cw[20] = ~cw[20];
    wr_in(cw);
    wr(IDX_ECC_TEST, 8'h05);
    rd_res();
    `CHK(r, {8'h00, DATA})
    rchk(IDX_FAULT_STAT, 8'h01);
    // double error keeps the single flag latched
    cw[50] = ~cw[50];
    wr_in(cw);
    wr(IDX_ECC_TEST, 8'h0D);
    rchk(IDX_FAULT_STAT, 8'h03);
    // a clean run does not clear the flags
    wr_in(enc(DATA));
    wr(IDX_ECC_TEST, 8'h05);
    rchk(IDX_FAULT_STAT, 8'h03);
    rd_res();
    `CHK(r, {8'h00, DATA})
    wr(IDX_FAULT_RESET, 8'h01);
    rchk(IDX_FAULT_STAT, 8'h00);
    // auto decoder, then a write without enable leaves results alone
    wr(IDX_ECC_TEST, 8'h01);
    rd_res();
    `CHK(r, {8'h00, AUTO_DATA})
    rchk(IDX_FAULT_STAT, 8'h01);
    wr(IDX_ECC_TEST, 8'h02);
    rd_res();
    `CHK(r, {8'h00, AUTO_DATA})
    // auto double-error test raises its own flag, byte nine stays zero
    wr(IDX_ECC_TEST, 8'h09);
    rchk(IDX_FAULT_STAT, 8'h03);
    rchk(IDX_ECC_OUT9, 8'h00);
    rchk(IDX_IRQ_STAT, 8'h1C);
    `CHK(irq, 1'b0)
    report_and_stop();
  end
endmodule : otp_program_ecc_selftest_tb
